//--- tb/ldc_control_bench.sv
`default_nettype none
module ldc_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic       adc_done = 1'b0;
	logic [7:0] reg_addr = 8'h00, wr_data = 8'h00;
	logic [5:0] adc_code = 6'h00;
	wire  [7:0] rd_data, table_one_data;
	wire  [8:0] table_one_addr, table_two_addr;
	wire  [7:0] table_two_data, dac_one_in, dac_two_in;
	wire  [1:0] gen_one_fullscale_sel, gen_two_fullscale_sel;
	wire        wr_ack, wr_nack, gen_one_direction, gen_two_direction;
	wire        reference_source_sel, adc_input_sel, write_enable_latch;
	int         failures = 0, n_compared = 0;
	always #4 clk = ~clk;
	ldc_control ldc_control_i (.*);
	ldc_table_model ldc_table_model_i (.*);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Inputs move 1 ns after the edge so the design samples them cleanly
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
		step(1);
		reg_addr = a;
		wr_data = d;
		wr_stb = 1'b1;
		step(1);
		wr_stb = 1'b0;
		chk({6'h00, wr_ack, wr_nack}, {6'h00, ok, !ok});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		step(1);
		reg_addr = a;
		rd_stb = 1'b1;
		step(1);
		rd_stb = 1'b0;
		chk(rd_data, exp);
	endtask
	task adc(input logic [5:0] code);
		step(1);
		adc_code = code;
		adc_done = 1'b1;
		step(1);
		adc_done = 1'b0;
	endtask
	task results;
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog: a hang counts as a mismatch
	initial begin
		#200000;
		failures++;
		results;
	end
	initial begin
		step(5);
		rst_n = 1'b1;
		chk(dac_one_in, 8'h00);
		chk(table_two_addr, 8'hd0);
		rd(8'h86, 8'h00);
		wr(8'h85, 8'h55, 1'b0);
		rd(8'h85, 8'h00);
		wr(8'h86, 8'h80, 1'b1);
		wr(8'h86, 8'h7f, 1'b1);
		rd(8'h86, 8'h80);
		$display("latch test done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h85, {4'h0, c[1:0], c[1:0]}, 1'b1);
			step(2);
			chk({4'h0, gen_two_fullscale_sel, gen_one_fullscale_sel},
				{4'h0, c[1:0], c[1:0]});
		end
		wr(8'h83, 8'h3c, 1'b1);
		wr(8'h84, 8'hc3, 1'b1);
		wr(8'h81, 8'h05, 1'b1);
		wr(8'h82, 8'h3f, 1'b1);
		wr(8'h85, 8'ha0, 1'b1);
		step(3);
		chk(dac_one_in, 8'h3c);
		chk(dac_two_in, 8'hc3);
		wr(8'h85, 8'h50, 1'b1);
		step(3);
		chk(table_one_addr, 8'h95);
		chk(table_two_addr, 9'h10f);
		chk(dac_one_in, 8'h95 ^ 8'h3c);
		chk(dac_two_in, 8'h0f ^ 8'h3c);
		$display("steering test done");
		wr(8'h85, 8'h00, 1'b1);
		repeat (3) adc(6'h2a);
		rd(8'h87, 8'h00);
		chk(dac_two_in, 8'h00);
		adc(6'h2a);
		rd(8'h87, 8'ha8);
		step(3);
		chk(dac_one_in, 8'hba ^ 8'h3c);
		wr(8'h80, 8'h1f, 1'b1);
		step(2);
		chk({4'h0, gen_two_direction, gen_one_direction, adc_input_sel,
			reference_source_sel}, 8'h0f);
		adc(6'h15);
		rd(8'h87, 8'h54);
		wr(8'h87, 8'hff, 1'b1);
		rd(8'h87, 8'h54);
		wr(8'h86, 8'h00, 1'b1);
		wr(8'h85, 8'h33, 1'b0);
		$display("converter test done");
		results;
	end
endmodule
bind ldc_control ldc_control_monitor ldc_control_monitor_i (.*);
`default_nettype wire

//--- tb/ldc_control_monitor.sv
`default_nettype none
// Register bus and table address relations seen at the ports
module ldc_control_monitor (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Register access
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic       wr_ack,
	input wire logic       wr_nack,
	// Table addresses and latch
	input wire logic [8:0] table_one_addr,
	input wire logic [8:0] table_two_addr,
	input wire logic       write_enable_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Writes to the latch register bypass the latch itself
	wire logic wen = wr_stb && reg_addr == 8'h86;
	a_latch_write_ack: assert property (wen |=> wr_ack && !wr_nack)
		else $error("latch write not acked");
	a_locked_write_nack: assert property (wr_stb && !wen && !write_enable_latch
		|=> wr_nack && !wr_ack)
		else $error("locked write not refused");
	a_latch_set_code: assert property (wen && wr_data == 8'h80
		|=> write_enable_latch)
		else $error("latch not set");
	a_latch_clear_code: assert property (wen && wr_data == 8'h00
		|=> !write_enable_latch)
		else $error("latch not cleared");
	a_latch_holds_value: assert property (!wen |=> $stable(write_enable_latch))
		else $error("latch moved without write");
	a_status_low_zero: assert property (rd_stb && reg_addr == 8'h87
		|=> rd_data[1:0] == 2'b00)
		else $error("status reserved bits set");
	a_table_one_span: assert property (table_one_addr inside {[9'h090:9'h0cf]})
		else $error("table one address out of span");
	a_table_two_span: assert property (table_two_addr inside {[9'h0d0:9'h10f]})
		else $error("table two address out of span");
	c_latch_set: cover property (wen && wr_data == 8'h80);
	c_refused: cover property (wr_nack);
	c_status_read: cover property (rd_stb && reg_addr == 8'h87);
endmodule
`default_nettype wire

//--- tb/ldc_table_model.sv
`default_nettype none
// Table memory: contents follow the address so a wrong row shows up
module ldc_table_model (
	// Row byte addresses
	input  wire logic [8:0] table_one_addr,
	input  wire logic [8:0] table_two_addr,
	// Row contents, combinational read
	output wire logic [7:0] table_one_data,
	output wire logic [7:0] table_two_data
);
	timeunit 1ns;
	timeprecision 1ps;
	assign table_one_data = table_one_addr[7:0] ^ 8'h3c;
	assign table_two_data = table_two_addr[7:0] ^ 8'h3c;
endmodule
`default_nettype wire

//--- verilog/ldc_control.v
`include "ldc_map.vh"
`default_nettype none
module ldc_control (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Register access from the serial slave
	input  wire       wr_stb,
	input  wire       rd_stb,
	input  wire [7:0] reg_addr,
	input  wire [7:0] wr_data,
	output reg  [7:0] rd_data,
	output reg        wr_ack,
	output reg        wr_nack,
	// Converter result
	input  wire       adc_done,
	input  wire [5:0] adc_code,
	// Table memory read port
	output reg  [8:0] table_one_addr,
	output reg  [8:0] table_two_addr,
	input  wire [7:0] table_one_data,
	input  wire [7:0] table_two_data,
	// Analog steering and write enable latch
	output reg  [7:0] dac_one_in,
	output reg  [7:0] dac_two_in,
	output reg  [1:0] gen_one_fullscale_sel,
	output reg  [1:0] gen_two_fullscale_sel,
	output reg        gen_one_direction,
	output reg        gen_two_direction,
	output reg        reference_source_sel,
	output reg        adc_input_sel,
	output reg        write_enable_latch
);

	reg  [7:0] ctrl0_q;
	reg  [5:0] row1_q;
	reg  [5:0] row2_q;
	reg  [7:0] dac1_q;
	reg  [7:0] dac2_q;
	reg  [7:0] range_q;
	reg  [5:0] adc_result_q;
	reg  [5:0] cand_q;
	reg  [1:0] match_q;
	reg        valid_q;
	reg        seen_q;
	wire       wel_write;
	wire       ok_write;
	wire       adc_filter_disable;
	wire       table_one_direct_sel;
	wire       dac_one_direct_sel;
	wire       table_two_direct_sel;
	wire       dac_two_direct_sel;
	wire [5:0] row_one_sel;
	wire [5:0] row_two_sel;

	assign adc_filter_disable   = ctrl0_q[`LDC_BIT_FILT_OFF];
	assign table_one_direct_sel = range_q[`LDC_BIT_T1_DIRECT];
	assign dac_one_direct_sel   = range_q[`LDC_BIT_D1_DIRECT];
	assign table_two_direct_sel = range_q[`LDC_BIT_T2_DIRECT];
	assign dac_two_direct_sel   = range_q[`LDC_BIT_D2_DIRECT];

	// The latch register itself is always writable, else it could never set
	assign wel_write = wr_stb && (reg_addr == `LDC_ADDR_WREN);
	assign ok_write  = wr_stb && write_enable_latch && !wel_write;

	// Write acknowledge answers one cycle after the strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ack  <= 1'b0;
			wr_nack <= 1'b0;
		end else begin
			wr_ack  <= ok_write || wel_write;
			wr_nack <= wr_stb && !write_enable_latch && !wel_write;
		end
	end

	// Write enable latch; only the two exact codes change it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
		end else if (wel_write && wr_data == `LDC_WEL_SET) begin
			write_enable_latch <= 1'b1;
		end else if (wel_write && wr_data == `LDC_WEL_CLR) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Control registers, all gated by the latch
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_q <= `LDC_CTRL_RESET;
			row1_q  <= 6'h00;
			row2_q  <= 6'h00;
			dac1_q  <= `LDC_CTRL_RESET;
			dac2_q  <= `LDC_CTRL_RESET;
			range_q <= `LDC_CTRL_RESET;
		end else if (ok_write) begin
			case (reg_addr)
			`LDC_ADDR_CTRL0: ctrl0_q <= wr_data;
			`LDC_ADDR_ROW1:  row1_q  <= wr_data[5:0];
			`LDC_ADDR_ROW2:  row2_q  <= wr_data[5:0];
			`LDC_ADDR_DAC1:  dac1_q  <= wr_data;
			`LDC_ADDR_DAC2:  dac2_q  <= wr_data;
			`LDC_ADDR_RANGE: range_q <= wr_data;
			default: ;
			endcase
		end
	end

	// Read mux; reserved bits and unmapped addresses read zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (rd_stb) begin
			case (reg_addr)
			`LDC_ADDR_CTRL0:  rd_data <= ctrl0_q;
			`LDC_ADDR_ROW1:   rd_data <= {2'b00, row1_q};
			`LDC_ADDR_ROW2:   rd_data <= {2'b00, row2_q};
			`LDC_ADDR_DAC1:   rd_data <= dac1_q;
			`LDC_ADDR_DAC2:   rd_data <= dac2_q;
			`LDC_ADDR_RANGE:  rd_data <= range_q;
			`LDC_ADDR_WREN:   rd_data <= {write_enable_latch, 7'h00};
			`LDC_ADDR_STATUS: rd_data <= {adc_result_q, 2'b00};
			default:          rd_data <= 8'h00;
			endcase
		end
	end

	// Conversion filter: count repeats of the same code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q       <= 6'h00;
			match_q      <= 2'h0;
			adc_result_q <= 6'h00;
			valid_q      <= 1'b0;
		end else if (adc_done) begin
			cand_q <= adc_code;
			if (adc_filter_disable) begin
				adc_result_q <= adc_code;
				valid_q      <= 1'b1;
				match_q      <= 2'h0;
			end else if (adc_code != cand_q || !seen_q) begin
				match_q <= 2'h1;
			end else if (match_q == `LDC_FILT_COUNT) begin
				adc_result_q <= adc_code;
				valid_q      <= 1'b1;
			end else begin
				match_q <= match_q + 2'h1;
			end
		end
	end

	// First conversion marks that the candidate holds a real code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else if (adc_done) begin
			seen_q <= 1'b1;
		end
	end

	assign row_one_sel = table_one_direct_sel ? row1_q : adc_result_q;
	assign row_two_sel = table_two_direct_sel ? row2_q : adc_result_q;

	// Table addressing and DAC sources; table data arrives a cycle late
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			table_one_addr <= `LDC_TABLE_ONE_BASE;
			table_two_addr <= `LDC_TABLE_TWO_BASE;
			dac_one_in     <= `LDC_DAC_RESET;
			dac_two_in     <= `LDC_DAC_RESET;
		end else begin
			table_one_addr <= `LDC_TABLE_ONE_BASE + {3'b000, row_one_sel};
			table_two_addr <= `LDC_TABLE_TWO_BASE + {3'b000, row_two_sel};
			if (dac_one_direct_sel)
				dac_one_in <= dac1_q;
			else if (valid_q || table_one_direct_sel)
				dac_one_in <= table_one_data;
			else
				dac_one_in <= `LDC_DAC_RESET;
			if (dac_two_direct_sel)
				dac_two_in <= dac2_q;
			else if (valid_q || table_two_direct_sel)
				dac_two_in <= table_two_data;
			else
				dac_two_in <= `LDC_DAC_RESET;
		end
	end

	// Analog steering straight from the control bits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_one_fullscale_sel <= 2'b00;
			gen_two_fullscale_sel <= 2'b00;
			gen_one_direction     <= 1'b0;
			gen_two_direction     <= 1'b0;
			reference_source_sel  <= 1'b0;
			adc_input_sel         <= 1'b0;
		end else begin
			gen_one_fullscale_sel <= range_q[1:0];
			gen_two_fullscale_sel <= range_q[3:2];
			gen_one_direction     <= ctrl0_q[`LDC_BIT_DIR_ONE];
			gen_two_direction     <= ctrl0_q[`LDC_BIT_DIR_TWO];
			reference_source_sel  <= ctrl0_q[`LDC_BIT_REF_SEL];
			adc_input_sel         <= ctrl0_q[`LDC_BIT_ADC_IN];
		end
	end

endmodule
`default_nettype wire

//--- verilog/ldc_map.vh
`ifndef LDC_MAP_VH
`define LDC_MAP_VH
// Register byte addresses
`define LDC_ADDR_CTRL0      8'h80
`define LDC_ADDR_ROW1       8'h81
`define LDC_ADDR_ROW2       8'h82
`define LDC_ADDR_DAC1       8'h83
`define LDC_ADDR_DAC2       8'h84
`define LDC_ADDR_RANGE      8'h85
`define LDC_ADDR_WREN       8'h86
`define LDC_ADDR_STATUS     8'h87
// Table base addresses
// Nine bits wide: table two runs past FFh up to 10Fh
`define LDC_TABLE_ONE_BASE  9'h090
`define LDC_TABLE_TWO_BASE  9'h0d0
// Control register 0 bit positions
`define LDC_BIT_REF_SEL     0
`define LDC_BIT_ADC_IN      1
`define LDC_BIT_FILT_OFF    2
`define LDC_BIT_DIR_ONE     3
`define LDC_BIT_DIR_TWO     4
// Range and bypass bit positions
`define LDC_BIT_T1_DIRECT   4
`define LDC_BIT_D1_DIRECT   5
`define LDC_BIT_T2_DIRECT   6
`define LDC_BIT_D2_DIRECT   7
// Write enable codes
`define LDC_WEL_SET         8'h80
`define LDC_WEL_CLR         8'h00
`define LDC_WEL_BIT         7
// Reset values
`define LDC_CTRL_RESET      8'h00
`define LDC_DAC_RESET       8'h00
// Identical conversions seen before the one that updates the result
`define LDC_FILT_COUNT      2'h3
`endif
